// *** hdl/debug_port_pkg.sv ***
// Purpose: shared constants and types of the serial debug port
// Assumes: ref_clk domain; test pins are sampled, not used as clocks
// Notes:   cpu addresses are full byte addresses of 16-bit registers
package debug_port_pkg;
   localparam int          ADDR_W          = 32;
   localparam int          REG_W           = 16;
   localparam int          DR_W            = 32;
   localparam int          IR_LEN          = 4;
   localparam logic [31:0] ADDR_INSTR      = 32'hFFFFF7C0;
   localparam logic [31:0] ADDR_STATUS     = 32'hFFFFF7C2;
   localparam logic [31:0] ADDR_DATA_UPPER = 32'hFFFFF7C4;
   localparam logic [31:0] ADDR_DATA_LOWER = 32'hFFFFF7C6;
   localparam logic [15:0] INSTR_RESET     = 16'hF000;
   localparam logic [15:0] STATUS_RESET    = 16'h0201;
   localparam logic [15:0] STATUS_FIXED    = 16'h0200;
   localparam logic [15:0] STATUS_ZERO_MSK = 16'hFDFE;
   localparam logic [11:0] INSTR_LOW_ZERO  = 12'h000;
   localparam int          FLAG_BIT        = 0;
   localparam logic [3:0]  CODE_INTERRUPT  = 4'hA;
   localparam logic [3:0]  CODE_BYPASS     = 4'hF;
   localparam logic [3:0]  IR_CAPTURE      = 4'h1;
   localparam int          FIFO_DEPTH      = 8;

   typedef enum logic [3:0] {
      TAP_RESET   = 4'hF,
      TAP_IDLE    = 4'hC,
      TAP_SEL_DR  = 4'h7,
      TAP_CAP_DR  = 4'h6,
      TAP_SH_DR   = 4'h2,
      TAP_EX1_DR  = 4'h1,
      TAP_PAU_DR  = 4'h3,
      TAP_EX2_DR  = 4'h0,
      TAP_UPD_DR  = 4'h5,
      TAP_SEL_IR  = 4'h4,
      TAP_CAP_IR  = 4'hE,
      TAP_SH_IR   = 4'hA,
      TAP_EX1_IR  = 4'h9,
      TAP_PAU_IR  = 4'hB,
      TAP_EX2_IR  = 4'h8,
      TAP_UPD_IR  = 4'hD
   } tap_state_t;

   typedef struct packed {
      logic        sel;
      logic        wr;
      logic [31:0] addr;
      logic [15:0] wdata;
   } cpu_req_t;

   typedef struct packed {
      logic        ack;
      logic [15:0] rdata;
   } cpu_rsp_t;
endpackage

// *** hdl/serial_debug_port.sv ***
// Purpose: serial debug port with test access controller and cpu registers
// Assumes: test clock far slower than ref_clk; trst_n async active low
// Notes:   test pins pass two flip-flops; tck edges are found in ref_clk
`timescale 1ns/1ns

module word_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 8
) (
   input  wire logic             ref_clk,
   input  wire logic             trst_n,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int PW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW:0]      wr_ptr_ff;
   logic [PW:0]      rd_ptr_ff;
   wire              push = in_valid & in_ready;
   wire              pop  = out_valid & out_ready;
   wire  [PW:0]      used = wr_ptr_ff - rd_ptr_ff;

   assign in_ready  = (used != (PW+1)'(DEPTH));
   assign out_valid = (used != '0);
   assign out_data  = mem[rd_ptr_ff[PW-1:0]];

   // storage carries no reset: data content is undefined until written
   always_ff @(posedge ref_clk) begin
      if (push) begin
         mem[wr_ptr_ff[PW-1:0]] <= in_data;
      end
   end

   always_ff @(posedge ref_clk or negedge trst_n) begin
      if (!trst_n) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
      end else begin
         wr_ptr_ff <= wr_ptr_ff + (PW+1)'(push);
         rd_ptr_ff <= rd_ptr_ff + (PW+1)'(pop);
      end
   end
endmodule

// Operation
// [RL1] whole port runs from test clock edges; code clocks all from ref_clk, tck rises step only the test logic
// [RL2] tms sampled on tck rise, steps controller
// [RL3] tdi sampled on tck rise while shifting
// [RL4] tdo driven only while shifting, else released
// [RL5] trst_n low resets port asynchronously
// [RL6] instruction four bits, last four kept
// [RL7] bits 15:12 code; A interrupt, F bypass
// [RL8] test reset loads F000; others leave it
// [RL9] instruction readable by cpu, writes ignored
// [RL10] interrupt instruction raises interrupt request
// [RL11] bypass uses single bit stage, cpu-invisible
// [RL12] status shifts out flag first, then reserved
// [RL13] status readable serially, ignores serial input
// [RL14] test reset loads status 0201
// [RL15] status bit 9 one, other reserved zero
// [RL16] bit 0 flag: one busy, zero cpu access
// [RL17] data exchanges 32 bits, last 32 kept
// [RL18] data enters at msb, leaves from lsb
// [RL19] data register never reset
// [RL20] cpu sees data as upper and lower halves
// [RL21] flag set by reset, cpu, bypass; cleared by shift
// [RL22] path shows status, then data after flag seen
// [RL23] five tms-high edges reset the port
// [RL24] standard sixteen-state test access controller
module serial_debug_port #(
   parameter int DATA_W     = debug_port_pkg::DR_W,
   parameter int HALF_W     = debug_port_pkg::REG_W,
   parameter int IR_W       = debug_port_pkg::IR_LEN,
   parameter int FIFO_DEPTH = debug_port_pkg::FIFO_DEPTH
) (
   input  wire logic                      ref_clk,
   input  wire logic                      reset_n,
   input  wire logic                      trst_n,
   input  wire logic                      tck,
   input  wire logic                      tms,
   input  wire logic                      tdi,
   output logic                           tdo_out,
   output logic                           tdo_oe_n,
   output logic                           irq_req,
   input  wire debug_port_pkg::cpu_req_t  cpu_req,
   output debug_port_pkg::cpu_rsp_t       cpu_rsp
);
   // next controller state for one tck rise at the given tms level
   function automatic debug_port_pkg::tap_state_t tap_step(
      input debug_port_pkg::tap_state_t cur,
      input logic                       mode
   );
      debug_port_pkg::tap_state_t nxt;
      nxt = cur;
      unique case (cur)
         debug_port_pkg::TAP_RESET:
            nxt = mode ? debug_port_pkg::TAP_RESET : debug_port_pkg::TAP_IDLE;
         debug_port_pkg::TAP_IDLE:
            nxt = mode ? debug_port_pkg::TAP_SEL_DR : debug_port_pkg::TAP_IDLE;
         debug_port_pkg::TAP_SEL_DR:
            nxt = mode ? debug_port_pkg::TAP_SEL_IR
                       : debug_port_pkg::TAP_CAP_DR;
         debug_port_pkg::TAP_CAP_DR:
            nxt = mode ? debug_port_pkg::TAP_EX1_DR
                       : debug_port_pkg::TAP_SH_DR;
         debug_port_pkg::TAP_SH_DR:
            nxt = mode ? debug_port_pkg::TAP_EX1_DR
                       : debug_port_pkg::TAP_SH_DR;
         debug_port_pkg::TAP_EX1_DR:
            nxt = mode ? debug_port_pkg::TAP_UPD_DR
                       : debug_port_pkg::TAP_PAU_DR;
         debug_port_pkg::TAP_PAU_DR:
            nxt = mode ? debug_port_pkg::TAP_EX2_DR
                       : debug_port_pkg::TAP_PAU_DR;
         debug_port_pkg::TAP_EX2_DR:
            nxt = mode ? debug_port_pkg::TAP_UPD_DR
                       : debug_port_pkg::TAP_SH_DR;
         debug_port_pkg::TAP_UPD_DR:
            nxt = mode ? debug_port_pkg::TAP_SEL_DR : debug_port_pkg::TAP_IDLE;
         debug_port_pkg::TAP_SEL_IR:
            nxt = mode ? debug_port_pkg::TAP_RESET
                       : debug_port_pkg::TAP_CAP_IR;
         debug_port_pkg::TAP_CAP_IR:
            nxt = mode ? debug_port_pkg::TAP_EX1_IR
                       : debug_port_pkg::TAP_SH_IR;
         debug_port_pkg::TAP_SH_IR:
            nxt = mode ? debug_port_pkg::TAP_EX1_IR
                       : debug_port_pkg::TAP_SH_IR;
         debug_port_pkg::TAP_EX1_IR:
            nxt = mode ? debug_port_pkg::TAP_UPD_IR
                       : debug_port_pkg::TAP_PAU_IR;
         debug_port_pkg::TAP_PAU_IR:
            nxt = mode ? debug_port_pkg::TAP_EX2_IR
                       : debug_port_pkg::TAP_PAU_IR;
         debug_port_pkg::TAP_EX2_IR:
            nxt = mode ? debug_port_pkg::TAP_UPD_IR
                       : debug_port_pkg::TAP_SH_IR;
         debug_port_pkg::TAP_UPD_IR:
            nxt = mode ? debug_port_pkg::TAP_SEL_DR : debug_port_pkg::TAP_IDLE;
      endcase
      return nxt;
   endfunction

   logic                       trst_s1_ff;
   logic                       trst_s2_ff;
   logic                       tck_s1_ff;
   logic                       tck_s2_ff;
   logic                       tck_d_ff;
   logic                       tms_s1_ff;
   logic                       tms_s2_ff;
   logic                       tdi_s1_ff;
   logic                       tdi_s2_ff;
   debug_port_pkg::tap_state_t tap_state_ff;
   debug_port_pkg::tap_state_t nxt_tap_state;
   logic [IR_W-1:0]            ir_sr_ff;
   logic [IR_W-1:0]            nxt_ir_sr;
   logic [IR_W-1:0]            instr_code_ff;
   logic [IR_W-1:0]            nxt_instr_code;
   logic [DATA_W-1:0]          dr_sr_ff;
   logic [DATA_W-1:0]          nxt_dr_sr;
   logic                       byp_ff;
   logic                       nxt_byp;
   logic                       sel_data_ff;
   logic                       nxt_sel_data;
   logic                       cap_flag_ff;
   logic                       nxt_cap_flag;
   logic                       shifted_ff;
   logic                       nxt_shifted;
   logic                       flag_ff;
   logic                       nxt_flag;
   logic [DATA_W-1:0]          data_ff;
   logic [DATA_W-1:0]          nxt_data;
   logic                       tdo_out_ff;
   logic                       nxt_tdo_out;
   logic                       tdo_oe_n_ff;
   logic                       irq_req_ff;
   logic                       ack_ff;
   logic [HALF_W-1:0]          rdata_ff;
   logic [HALF_W-1:0]          nxt_rdata;
   logic [HALF_W-1:0]          rd_mux;
   logic                       fifo_in_ready;
   logic                       fifo_out_valid;
   logic [DATA_W-1:0]          fifo_out_data;

   // test logic leaves reset only after two ref_clk edges
   wire test_rst_n = trst_s2_ff;
   // tck is only sampled; controller and shift steps wait for a found rise
   wire tck_rise   = tck_s2_ff & ~tck_d_ff; // [RL1]

   wire st_reset   = (tap_state_ff == debug_port_pkg::TAP_RESET);
   wire st_cap_ir  = (tap_state_ff == debug_port_pkg::TAP_CAP_IR);
   wire st_sh_ir   = (tap_state_ff == debug_port_pkg::TAP_SH_IR);
   wire st_upd_ir  = (tap_state_ff == debug_port_pkg::TAP_UPD_IR);
   wire st_cap_dr  = (tap_state_ff == debug_port_pkg::TAP_CAP_DR);
   wire st_sh_dr   = (tap_state_ff == debug_port_pkg::TAP_SH_DR);
   wire st_upd_dr  = (tap_state_ff == debug_port_pkg::TAP_UPD_DR);
   wire shift_any  = st_sh_ir | st_sh_dr;
   wire cap_ir     = tck_rise & st_cap_ir;
   wire sh_ir      = tck_rise & st_sh_ir;
   wire upd_ir     = tck_rise & st_upd_ir;
   wire cap_dr     = tck_rise & st_cap_dr;
   wire sh_dr      = tck_rise & st_sh_dr;
   wire upd_dr     = tck_rise & st_upd_dr;

   wire is_bypass    = (instr_code_ff ==
                        IR_W'(debug_port_pkg::CODE_BYPASS)); // [RL7]
   wire is_interrupt = (instr_code_ff ==
                        IR_W'(debug_port_pkg::CODE_INTERRUPT)); // [RL7]
   // reserved codes fall back to the one-bit stage
   wire use_bypass   = ~is_interrupt; // [RL11]

   wire cpu_take   = cpu_req.sel & ~ack_ff;
   wire cpu_write  = cpu_take & cpu_req.wr;
   wire hit_instr  = (cpu_req.addr == debug_port_pkg::ADDR_INSTR);
   wire hit_status = (cpu_req.addr == debug_port_pkg::ADDR_STATUS);
   wire hit_upper  = (cpu_req.addr == debug_port_pkg::ADDR_DATA_UPPER);
   wire hit_lower  = (cpu_req.addr == debug_port_pkg::ADDR_DATA_LOWER);
   wire wr_instr   = cpu_write & hit_instr;
   wire wr_status  = cpu_write & hit_status;
   wire wr_upper   = cpu_write & hit_upper;
   wire wr_lower   = cpu_write & hit_lower;

   wire [HALF_W-1:0] instr_word  =
      HALF_W'({instr_code_ff, debug_port_pkg::INSTR_LOW_ZERO}); // [RL7]
   wire [HALF_W-1:0] status_word =
      HALF_W'(debug_port_pkg::STATUS_FIXED) |
      (HALF_W'(flag_ff) << debug_port_pkg::FLAG_BIT); // [RL15] [RL16]
   // flag sits in the lsb, so it is the first bit out
   wire [DATA_W-1:0] cap_word    =
      sel_data_ff ? data_ff : DATA_W'(status_word); // [RL12] [RL22]

   wire data_done   = upd_dr & ~use_bypass & shifted_ff & sel_data_ff;
   wire status_done = upd_dr & ~use_bypass & shifted_ff & ~sel_data_ff &
                      cap_flag_ff;
   // set wins over a clear in the same cycle
   wire flag_set    = st_reset | is_bypass |
                      (wr_status &
                       cpu_req.wdata[debug_port_pkg::FLAG_BIT]); // [RL21]
   wire flag_clr    = fifo_out_valid; // [RL21]

   assign nxt_tap_state  = tck_rise ? tap_step(tap_state_ff, tms_s2_ff)
                                    : tap_state_ff; // [RL2] [RL24]
   assign nxt_ir_sr      = cap_ir ? IR_W'(debug_port_pkg::IR_CAPTURE) :
                           sh_ir  ? {tdi_s2_ff, ir_sr_ff[IR_W-1:1]} :
                                    ir_sr_ff; // [RL3] [RL6]
   // five tms-high rises always pass through the reset state
   assign nxt_instr_code = st_reset ? IR_W'(debug_port_pkg::CODE_BYPASS) :
                           upd_ir   ? ir_sr_ff :
                                      instr_code_ff; // [RL23] [RL6]
   // status is only captured, so shifting leaves it untouched
   assign nxt_dr_sr      = (cap_dr & ~use_bypass) ? cap_word :
                           (sh_dr & ~use_bypass)  ?
                              {tdi_s2_ff, dr_sr_ff[DATA_W-1:1]} :
                              dr_sr_ff; // [RL13] [RL17] [RL18]
   assign nxt_byp        = (cap_dr & use_bypass) ? 1'b0 :
                           (sh_dr & use_bypass)  ? tdi_s2_ff :
                                                   byp_ff; // [RL11]
   assign nxt_shifted    = cap_dr ? 1'b0 : sh_dr ? 1'b1 : shifted_ff;
   assign nxt_cap_flag   = cap_dr ? flag_ff : cap_flag_ff;
   assign nxt_sel_data   = st_reset    ? 1'b0 :
                           data_done   ? 1'b0 :
                           status_done ? 1'b1 :
                                         sel_data_ff; // [RL22]
   assign nxt_flag       = flag_set ? 1'b1 :
                           flag_clr ? 1'b0 :
                                      flag_ff;
   assign nxt_tdo_out    = ~shift_any ? tdo_out_ff :
                           st_sh_ir   ? ir_sr_ff[0] :
                           use_bypass ? byp_ff :
                                        dr_sr_ff[0]; // [RL4] [RL18]
   // a serial word beats a cpu write landing in the same cycle
   assign nxt_data       = fifo_out_valid ? fifo_out_data :
                           wr_upper ? {HALF_W'(cpu_req.wdata),
                                       data_ff[HALF_W-1:0]} :
                           wr_lower ? {data_ff[DATA_W-1:HALF_W],
                                       HALF_W'(cpu_req.wdata)} :
                                      data_ff; // [RL20]
   assign rd_mux         = hit_instr  ? instr_word :
                           hit_status ? status_word :
                           hit_upper  ? data_ff[DATA_W-1:HALF_W] :
                           hit_lower  ? data_ff[HALF_W-1:0] :
                                        '0; // [RL9] [RL20]
   assign nxt_rdata      = (cpu_take & ~cpu_req.wr) ? rd_mux : rdata_ff;

   assign tdo_out       = tdo_out_ff;
   assign tdo_oe_n      = tdo_oe_n_ff;
   assign irq_req       = irq_req_ff;
   assign cpu_rsp.ack   = ack_ff;
   assign cpu_rsp.rdata = rdata_ff;

   // assert at once, release through two flops
   always_ff @(posedge ref_clk or negedge trst_n) begin
      if (!trst_n) begin
         trst_s1_ff <= 1'b0; // [RL5]
         trst_s2_ff <= 1'b0;
      end else begin
         trst_s1_ff <= 1'b1;
         trst_s2_ff <= trst_s1_ff;
      end
   end

   always_ff @(posedge ref_clk or negedge test_rst_n) begin
      if (!test_rst_n) begin
         tck_s1_ff <= 1'b0;
         tck_s2_ff <= 1'b0;
         tck_d_ff  <= 1'b0;
         tms_s1_ff <= 1'b1;
         tms_s2_ff <= 1'b1;
         tdi_s1_ff <= 1'b1;
         tdi_s2_ff <= 1'b1;
      end else begin
         tck_s1_ff <= tck;
         tck_s2_ff <= tck_s1_ff;
         tck_d_ff  <= tck_s2_ff;
         tms_s1_ff <= tms;
         tms_s2_ff <= tms_s1_ff;
         tdi_s1_ff <= tdi;
         tdi_s2_ff <= tdi_s1_ff;
      end
   end

   // system reset_n deliberately leaves this state alone
   always_ff @(posedge ref_clk or negedge test_rst_n) begin
      if (!test_rst_n) begin
         tap_state_ff  <= debug_port_pkg::TAP_RESET;
         ir_sr_ff      <= IR_W'(debug_port_pkg::IR_CAPTURE);
         instr_code_ff <= IR_W'(debug_port_pkg::CODE_BYPASS); // [RL8]
         dr_sr_ff      <= '0;
         byp_ff        <= 1'b0;
         shifted_ff    <= 1'b0;
         cap_flag_ff   <= 1'b0;
         sel_data_ff   <= 1'b0;
         flag_ff       <= debug_port_pkg::STATUS_RESET[0]; // [RL14]
         tdo_out_ff    <= 1'b0;
         tdo_oe_n_ff   <= 1'b1;
         irq_req_ff    <= 1'b0;
      end else begin
         tap_state_ff  <= nxt_tap_state;
         ir_sr_ff      <= nxt_ir_sr;
         instr_code_ff <= nxt_instr_code;
         dr_sr_ff      <= nxt_dr_sr;
         byp_ff        <= nxt_byp;
         shifted_ff    <= nxt_shifted;
         cap_flag_ff   <= nxt_cap_flag;
         sel_data_ff   <= nxt_sel_data;
         flag_ff       <= nxt_flag;
         tdo_out_ff    <= nxt_tdo_out;
         tdo_oe_n_ff   <= ~shift_any; // [RL4]
         irq_req_ff    <= is_interrupt; // [RL10]
      end
   end

   // no reset of any kind: content undefined until written
   always_ff @(posedge ref_clk) begin
      data_ff <= nxt_data; // [RL19]
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         ack_ff   <= 1'b0;
         rdata_ff <= '0;
      end else begin
         ack_ff   <= cpu_take;
         rdata_ff <= nxt_rdata;
      end
   end

   // decouples word completion from the cpu-side register
   word_fifo #(
      .WIDTH (DATA_W),
      .DEPTH (FIFO_DEPTH)
   ) i_word_fifo (
      .ref_clk   (ref_clk),
      .trst_n    (test_rst_n),
      .in_valid  (data_done),
      .in_ready  (fifo_in_ready),
      .in_data   (dr_sr_ff),
      .out_valid (fifo_out_valid),
      .out_ready (1'b1),
      .out_data  (fifo_out_data)
   );

   AST_TAP_HOLD: assert property (@(posedge ref_clk) // [RL2]
      disable iff (!test_rst_n)
      !tck_rise |=> $stable(tap_state_ff))
      else $error("controller moved without a test clock rise");

   AST_IR_CAPTURE: assert property (@(posedge ref_clk) // [RL24]
      disable iff (!test_rst_n)
      cap_ir |=> (ir_sr_ff == IR_W'(debug_port_pkg::IR_CAPTURE)))
      else $error("instruction capture word not loaded");

   AST_IR_UPDATE: assert property (@(posedge ref_clk) // [RL6]
      disable iff (!test_rst_n)
      upd_ir |=> (instr_code_ff == $past(ir_sr_ff)))
      else $error("instruction not taken from last shifted bits");

   AST_INSTR_RO: assert property (@(posedge ref_clk) // [RL9]
      disable iff (!test_rst_n)
      (wr_instr && !upd_ir && !st_reset) |=> $stable(instr_code_ff))
      else $error("cpu write changed the instruction");

   AST_IRQ: assert property (@(posedge ref_clk) // [RL10]
      disable iff (!test_rst_n)
      irq_req_ff == $past(is_interrupt))
      else $error("interrupt request does not follow instruction");

   AST_FLAG_SET: assert property (@(posedge ref_clk) // [RL21]
      disable iff (!test_rst_n)
      flag_set |=> flag_ff)
      else $error("transfer flag not set");

   AST_FLAG_CLR: assert property (@(posedge ref_clk) // [RL21]
      disable iff (!test_rst_n)
      (fifo_out_valid && !flag_set) |=> !flag_ff)
      else $error("transfer flag not cleared after data shift");

   AST_OE_SHIFT: assert property (@(posedge ref_clk) // [RL4]
      disable iff (!test_rst_n)
      !tdo_oe_n_ff |-> $past(shift_any))
      else $error("serial output driven outside shifting");

   AST_BYP_STAGE: assert property (@(posedge ref_clk) // [RL11]
      disable iff (!test_rst_n)
      (sh_dr && use_bypass) |=> (byp_ff == $past(tdi_s2_ff)))
      else $error("bypass stage did not take serial input");

   AST_STATUS_RD: assert property (@(posedge ref_clk) // [RL15]
      disable iff (!reset_n)
      (cpu_take && !cpu_req.wr && hit_status) |=>
         (((rdata_ff & HALF_W'(debug_port_pkg::STATUS_ZERO_MSK)) == '0) &&
          ((rdata_ff & HALF_W'(debug_port_pkg::STATUS_FIXED)) ==
           HALF_W'(debug_port_pkg::STATUS_FIXED))))
      else $error("status reserved bits read wrong");

   AST_FIFO_ROOM: assert property (@(posedge ref_clk) // [RL17]
      disable iff (!test_rst_n)
      data_done |-> fifo_in_ready)
      else $error("serial word dropped at full buffer");

   COV_IRQ: cover property (@(posedge ref_clk) disable iff (!test_rst_n)
      $rose(irq_req_ff));
   COV_TO_DATA: cover property (@(posedge ref_clk) disable iff (!test_rst_n)
      status_done);
   COV_DATA_IN: cover property (@(posedge ref_clk) disable iff (!test_rst_n)
      fifo_out_valid);
   COV_TMS_RST: cover property (@(posedge ref_clk) disable iff (!test_rst_n)
      $rose(st_reset));
endmodule

// *** tb/jtag_host.sv ***
// Purpose: test host on the serial debug pins
// Assumes: tck period 160 ns, idle low between frames
// Notes:   tdo sampled just before each tck rise
`timescale 1ns/1ns
module jtag_host (
   output logic      tck,
   output logic      tms,
   output logic      tdi,
   output logic      trst_n,
   input  wire logic tdo,
   output logic      [31:0] o
);
   logic q;
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b1;
      trst_n = 1'b0;
   end
   task automatic step(input logic m, input logic d);
      tms = m;
      tdi = d;
      #80 q = tdo;
      tck = 1'b1;
      #80 tck = 1'b0;
   endtask
   task automatic rst;
      #400 trst_n = 1'b1;
      step(1'b0, 1'b1);
   endtask
   // ir selects the instruction path: n is 4 there
   task automatic shift(input logic ir, input int n, input logic [31:0] v);
      step(1'b1, 1'b1);
      if (ir)
         step(1'b1, 1'b1);
      step(1'b0, 1'b1);
      step(1'b0, 1'b1);
      o = '0;
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, v[i]);
         o = {q, o[31:1]};
      end
      step(1'b1, 1'b1);
      step(1'b0, 1'b1);
   endtask
endmodule

// *** tb/serial_debug_port_tb.sv ***
// Purpose: self-checking bench of the serial debug port
// Assumes: cpu request held until ack
// Notes:   one host model drives all test pins
`timescale 1ns/1ns
module serial_debug_port_tb;
   logic ref_clk, reset_n, tck, tms, tdi, trst_n, tdo_out, tdo_oe_n, irq;
   logic [31:0] o;
   logic [15:0] rd;
   int fails, num_checks;
   debug_port_pkg::cpu_req_t cpu_req;
   debug_port_pkg::cpu_rsp_t cpu_rsp;
   serial_debug_port i_dut (.ref_clk(ref_clk), .reset_n(reset_n),
      .trst_n(trst_n), .tck(tck), .tms(tms), .tdi(tdi), .tdo_out(tdo_out),
      .tdo_oe_n(tdo_oe_n), .irq_req(irq), .cpu_req(cpu_req),
      .cpu_rsp(cpu_rsp));
   jtag_host i_host (.tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n),
      .tdo(tdo_out), .o(o));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("FAIL %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic cpu(input logic w, input logic [31:0] a,
                      input logic [15:0] d);
      @(posedge ref_clk) #1 cpu_req = '{1'b1, w, a, d};
      do @(negedge ref_clk); while (cpu_rsp.ack !== 1'b1);
      rd = cpu_rsp.rdata;
      @(posedge ref_clk) #1 cpu_req.sel = 1'b0;
   endtask
   task automatic complete_run;
      $display("fails %0d num_checks %0d", fails, num_checks);
      if (fails == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   initial begin
      #500000 fails++;
      complete_run;
   end
   initial begin
      cpu_req = '0;
      reset_n = 1'b0;
      repeat (16) @(posedge ref_clk);
      #1 reset_n = 1'b1;
      i_host.rst;
      cpu(1'b0, 32'hFFFFF7C2, 16'h0000);
      chk(rd, 32'h0201);
      cpu(1'b1, 32'hFFFFF7C0, 16'h0000);
      cpu(1'b0, 32'hFFFFF7C0, 16'h0000);
      chk(rd, 32'hF000);
      i_host.shift(1'b1, 4, 32'hA);
      chk(irq, 32'h1);
      cpu(1'b0, 32'hFFFFF7C0, 16'h0000);
      chk(rd, 32'hA000);
      i_host.shift(1'b0, 1, 32'h0);
      chk(o[31], 32'h1);
      i_host.shift(1'b0, 32, 32'h12345678);
      cpu(1'b0, 32'hFFFFF7C2, 16'h0000);
      chk(rd, 32'h0200);
      cpu(1'b0, 32'hFFFFF7C4, 16'h0000);
      chk(rd, 32'h1234);
      cpu(1'b1, 32'hFFFFF7C6, 16'hABCD);
      cpu(1'b1, 32'hFFFFF7C2, 16'h0201);
      i_host.shift(1'b0, 1, 32'h0);
      i_host.shift(1'b0, 32, 32'h0);
      chk(o, 32'h1234ABCD);
      chk(tdo_oe_n, 32'h1);
      repeat (5) i_host.step(1'b1, 1'b1);
      i_host.step(1'b0, 1'b1);
      cpu(1'b0, 32'hFFFFF7C0, 16'h0000);
      chk(rd, 32'hF000);
      chk(irq, 32'h0);
      complete_run;
   end
endmodule
